// file: shared/pfpr_pkg.sv
// Contract
// - loopback pin floats from reset until the data config register is written.
// - loopback pin drives high while line codec loopback is programmed; used internally too.
// - extended bus option turns the loopback pin into user output two.
// - user output two floats until bus master, then drives config two value.
// - compress output asserts on address match, or on mismatch, as software selects.
// - compress output set by config two bits 1 and 2; floats until written.
// - reject input low for two consecutive receive clocks discards current packet.
// - reject honoured up to the second-to-last received bit.
// - strap high selects first alternate pin definitions, low selects second.
// - strap high gives big endian byte order, low gives little endian.
// - as master, 16-bit data on lanes 15-0, 32-bit data on 31-0.
// - as slave, register read data only on lanes 15-0.
// - receive clock keeps running five bit times after carrier sense drops.
package pfpr_pkg;
   localparam logic [1:0] PFPR_ADDR_CFG     = 2'h0;
   localparam logic [1:0] PFPR_ADDR_CFG_TWO = 2'h1;
   localparam logic [1:0] PFPR_ADDR_STATUS  = 2'h2;
   localparam int PFPR_CFG_LOOPBACK_BIT  = 0;
   localparam int PFPR_CFG_EXT_BUS_BIT   = 1;
   localparam int PFPR_CFG2_USER_BIT     = 0;
   localparam int PFPR_CFG2_COMP_EN_BIT  = 1;
   localparam int PFPR_CFG2_COMP_INV_BIT = 2;
   localparam int PFPR_ST_STRAP_BIT      = 0;
   localparam int PFPR_ST_CFG_WR_BIT     = 1;
   localparam int PFPR_ST_CFG2_WR_BIT    = 2;
   localparam int PFPR_ST_REJECT_BIT     = 3;
   localparam int PFPR_ST_MASTER_BIT     = 4;
   localparam logic [2:0] PFPR_CFG_RESET  = 3'h0;
   localparam logic [31:0] PFPR_DATA_ZERO = 32'h0000_0000;
   localparam int PFPR_TAIL_BITS      = 5;
   localparam int PFPR_REJECT_SAMPLES = 2;
endpackage

// file: shared/pfpr_rx_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pfpr_rx_if;
   logic rx_clk_rise;
   logic carrier;
   logic reject_low;
   logic discard;
   logic in_frame;
   modport ctrl (output rx_clk_rise, output carrier, output reject_low,
                 input discard, input in_frame);
   modport filt (input rx_clk_rise, input carrier, input reject_low,
                 output discard, output in_frame);
endinterface
`default_nettype wire

// file: verilog/pfpr_reject_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pfpr_reject_filter
   import pfpr_pkg::*;
#(
   parameter int TAIL_BITS      = PFPR_TAIL_BITS,
   parameter int REJECT_SAMPLES = PFPR_REJECT_SAMPLES
)(
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic ce_i,
   pfpr_rx_if.filt   rx
);
   generate
      if (TAIL_BITS < 1 || TAIL_BITS > 15 || REJECT_SAMPLES < 1 || REJECT_SAMPLES > 15)
      begin : g_bad
         $error("pfpr_reject_filter: counts out of range");
      end
   endgenerate

   localparam logic [3:0] TAIL_INIT = 4'(TAIL_BITS);
   localparam logic [3:0] REJ_NEED  = 4'(REJECT_SAMPLES);

   typedef struct packed {
      logic [3:0] tail;
      logic [3:0] low_cnt;
      logic       done;
      logic       discard;
   } pfpr_filt_t;

   pfpr_filt_t st;
   pfpr_filt_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.discard = 1'b0;
      if (rx.carrier)
      begin
         next_st.tail = TAIL_INIT;
      end
      else if (rx.rx_clk_rise && st.tail != 4'h0)
      begin
         next_st.tail = st.tail - 4'h1;
      end
      if (!rx.carrier && st.tail == 4'h0)
      begin
         next_st.low_cnt = 4'h0;
         next_st.done    = 1'b0;
      end
      else if (rx.rx_clk_rise)
      begin
         if (!rx.reject_low)
         begin
            next_st.low_cnt = 4'h0;
         end
         else if (st.low_cnt != REJ_NEED)
         begin
            next_st.low_cnt = st.low_cnt + 4'h1;
         end
         if (rx.reject_low && st.low_cnt == REJ_NEED - 4'h1 && !st.done)
         begin
            next_st.discard = 1'b1;
            next_st.done    = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         st <= '0;
      end
      else if (ce_i)
      begin
         st <= next_st;
      end
   end

   assign rx.discard  = st.discard;
   assign rx.in_frame = rx.carrier || st.tail != 4'h0;
endmodule // pfpr_reject_filter
`default_nettype wire

// file: verilog/pfpr_top.sv
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pfpr_top
   import pfpr_pkg::*;
#(
   parameter int TAIL_BITS      = PFPR_TAIL_BITS,
   parameter int REJECT_SAMPLES = PFPR_REJECT_SAMPLES
)(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   // register bus
   input  wire logic [1:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // pins
   input  wire logic        bus_style_select_i,
   input  wire logic        receive_bit_clock_i,
   input  wire logic        carrier_sense_i,
   input  wire logic        packet_reject_in_i,
   output logic             loopback_indicator_o,
   output logic             loopback_indicator_oe_o,
   output logic             packet_compress_out_o,
   output logic             packet_compress_out_oe_o,
   output logic             mem_dir_o,
   output logic             irq_pin_o,
   output logic [31:0]      system_data_lines_o,
   output logic             system_data_lines_lo_oe_o,
   output logic             system_data_lines_hi_oe_o,
   // device-internal side
   input  wire logic        bus_master_i,
   input  wire logic        master_write_i,
   input  wire logic        master_read_i,
   input  wire logic        master_wide_i,
   input  wire logic [31:0] master_data_i,
   input  wire logic        slave_read_i,
   input  wire logic [15:0] slave_data_i,
   input  wire logic        match_valid_i,
   input  wire logic        match_hit_i,
   input  wire logic        irq_req_i,
   output logic             loopback_active_o,
   output logic             big_endian_o,
   output logic             packet_discard_o
);
   typedef struct packed {
      logic [1:0]  rej_sync;
      logic [1:0]  rclk_sync;
      logic [1:0]  crs_sync;
      logic [1:0]  strap_sync;
      logic        rclk_prev;
      logic        strap_taken;
      logic        big_end;
      logic [2:0]  cfg;
      logic [2:0]  cfg_two;
      logic        cfg_written;
      logic        cfg2_written;
      logic        became_master;
      logic        reject_seen;
      logic        waitreq;
      logic [31:0] rdata;
      logic        lpin;
      logic        lpin_oe;
      logic        comp;
      logic        comp_oe;
      logic        mem_dir;
      logic        irq_pin;
      logic [31:0] dout;
      logic        lo_oe;
      logic        hi_oe;
      logic        loop_int;
      logic        discard;
   } pfpr_state_t;

   pfpr_state_t st;
   pfpr_state_t next_st;
   pfpr_rx_if   rx_link ();

   function automatic logic [31:0] pfpr_order(input logic [31:0] d, input logic big);
      pfpr_order = big ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
   endfunction

   function automatic logic [31:0] pfpr_read_mux(input logic [1:0] a,
                                                 input pfpr_state_t s);
      logic [31:0] r;
      r = PFPR_DATA_ZERO;
      unique case (a)
         PFPR_ADDR_CFG:     r[2:0] = s.cfg;
         PFPR_ADDR_CFG_TWO: r[2:0] = s.cfg_two;
         PFPR_ADDR_STATUS:
         begin
            r[PFPR_ST_STRAP_BIT]   = s.big_end;
            r[PFPR_ST_CFG_WR_BIT]  = s.cfg_written;
            r[PFPR_ST_CFG2_WR_BIT] = s.cfg2_written;
            r[PFPR_ST_REJECT_BIT]  = s.reject_seen;
            r[PFPR_ST_MASTER_BIT]  = s.became_master;
         end
         default:           r = PFPR_DATA_ZERO;
      endcase
      pfpr_read_mux = r;
   endfunction

   assign rx_link.rx_clk_rise = st.rclk_sync[1] && !st.rclk_prev;
   assign rx_link.carrier     = st.crs_sync[1];
   assign rx_link.reject_low  = !st.rej_sync[1];

   pfpr_reject_filter #(
      .TAIL_BITS      (TAIL_BITS),
      .REJECT_SAMPLES (REJECT_SAMPLES)
   ) u_filter (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .rx        (rx_link.filt)
   );

   always_comb
   begin
      logic       wr_hit;
      logic       ext_bus;
      logic       loop_en;
      logic       strap;
      logic [2:0] wlo;
      wr_hit  = 1'b0;
      ext_bus = 1'b0;
      loop_en = 1'b0;
      strap   = 1'b0;
      wlo     = avs_writedata_i[2:0];
      next_st = st;
      next_st.rej_sync   = {st.rej_sync[0], packet_reject_in_i};
      next_st.rclk_sync  = {st.rclk_sync[0], receive_bit_clock_i};
      next_st.crs_sync   = {st.crs_sync[0], carrier_sense_i};
      next_st.strap_sync = {st.strap_sync[0], bus_style_select_i};
      next_st.rclk_prev  = st.rclk_sync[1];
      if (!st.strap_taken)
      begin
         next_st.strap_taken = 1'b1;
         next_st.big_end     = st.strap_sync[1];
      end
      strap = st.big_end;

      // bus slave: one wait cycle, write lands when waitrequest is seen low
      if (!st.waitreq)
      begin
         next_st.waitreq = 1'b1;
         wr_hit = avs_write_i && avs_byteenable_i[0];
      end
      else if (avs_read_i || avs_write_i)
      begin
         next_st.waitreq = 1'b0;
         next_st.rdata   = avs_read_i ? pfpr_read_mux(avs_address_i, st) : PFPR_DATA_ZERO;
      end
      if (wr_hit)
      begin
         unique case (avs_address_i)
            PFPR_ADDR_CFG:
            begin
               next_st.cfg         = wlo;
               next_st.cfg_written = 1'b1;
            end
            PFPR_ADDR_CFG_TWO:
            begin
               next_st.cfg_two      = wlo;
               next_st.cfg2_written = 1'b1;
            end
            PFPR_ADDR_STATUS:
            begin
               if (avs_writedata_i[PFPR_ST_REJECT_BIT])
               begin
                  next_st.reject_seen = 1'b0;
               end
            end
            default:
            begin
               next_st.cfg = st.cfg;
            end
         endcase
      end
      if (rx_link.discard)
      begin
         next_st.reject_seen = 1'b1;
      end
      next_st.discard = rx_link.discard;

      if (bus_master_i)
      begin
         next_st.became_master = 1'b1;
      end
      ext_bus = next_st.cfg[PFPR_CFG_EXT_BUS_BIT];
      loop_en = next_st.cfg[PFPR_CFG_LOOPBACK_BIT];
      next_st.loop_int = loop_en;
      if (ext_bus)
      begin
         next_st.lpin    = next_st.cfg_two[PFPR_CFG2_USER_BIT];
         next_st.lpin_oe = next_st.cfg_written && next_st.became_master;
      end
      else
      begin
         next_st.lpin    = loop_en;
         next_st.lpin_oe = next_st.cfg_written;
      end

      if (match_valid_i)
      begin
         next_st.comp = next_st.cfg_two[PFPR_CFG2_COMP_EN_BIT]
                        && (match_hit_i ^ next_st.cfg_two[PFPR_CFG2_COMP_INV_BIT]);
      end
      if (!next_st.cfg_two[PFPR_CFG2_COMP_EN_BIT])
      begin
         next_st.comp = 1'b0;
      end
      next_st.comp_oe = next_st.cfg2_written;

      next_st.mem_dir = strap ? master_read_i : !master_read_i;
      next_st.irq_pin = strap ? !irq_req_i : irq_req_i;

      next_st.lo_oe = 1'b0;
      next_st.hi_oe = 1'b0;
      next_st.dout  = PFPR_DATA_ZERO;
      if (bus_master_i && master_write_i)
      begin
         next_st.dout  = pfpr_order(master_data_i, strap);
         next_st.lo_oe = 1'b1;
         next_st.hi_oe = master_wide_i;
         if (!master_wide_i)
         begin
            next_st.dout[31:16] = 16'h0000;
         end
      end
      else if (!bus_master_i && slave_read_i)
      begin
         next_st.dout[15:0] = slave_data_i;
         next_st.lo_oe      = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         st          <= '0;
         st.cfg      <= PFPR_CFG_RESET;
         st.cfg_two  <= PFPR_CFG_RESET;
         st.waitreq  <= 1'b1;
         st.mem_dir  <= 1'b0;
         // pin synchronisers keep running, so the strap is settled at release
         st.rej_sync   <= {st.rej_sync[0], packet_reject_in_i};
         st.rclk_sync  <= {st.rclk_sync[0], receive_bit_clock_i};
         st.crs_sync   <= {st.crs_sync[0], carrier_sense_i};
         st.strap_sync <= {st.strap_sync[0], bus_style_select_i};
         st.rclk_prev  <= st.rclk_sync[1];
      end
      else if (ce_i)
      begin
         st <= next_st;
      end
   end

   assign avs_readdata_o            = st.rdata;
   assign avs_waitrequest_o         = st.waitreq;
   assign loopback_indicator_o      = st.lpin;
   assign loopback_indicator_oe_o   = st.lpin_oe;
   assign packet_compress_out_o     = st.comp;
   assign packet_compress_out_oe_o  = st.comp_oe;
   assign mem_dir_o                 = st.mem_dir;
   assign irq_pin_o                 = st.irq_pin;
   assign system_data_lines_o       = st.dout;
   assign system_data_lines_lo_oe_o = st.lo_oe;
   assign system_data_lines_hi_oe_o = st.hi_oe;
   assign loopback_active_o         = st.loop_int;
   assign big_endian_o              = st.big_end;
   assign packet_discard_o          = st.discard;
endmodule // pfpr_top
`default_nettype wire

// file: dv/pfpr_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pfpr_top_chk (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic bus_master_i,
   input wire logic master_write_i,
   input wire logic master_wide_i,
   input wire logic irq_req_i,
   input wire logic irq_pin_o,
   input wire logic big_endian_o,
   input wire logic loopback_indicator_oe_o,
   input wire logic packet_compress_out_oe_o,
   input wire logic system_data_lines_lo_oe_o,
   input wire logic system_data_lines_hi_oe_o,
   input wire logic packet_discard_o
);
   logic [1:0] up_q;
   always_ff @(posedge clk_i)
      if (sys_rst_i) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   oe_reset_a:
      assert property ($fell(sys_rst_i) |-> !loopback_indicator_oe_o && !packet_compress_out_oe_o)
      else $error("pin driven out of reset");
   bus_answer_a:
      assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
         |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer not one cycle");
   lo_lane_a:
      assert property (up_q == 2'h3 && ce_i && bus_master_i && master_write_i
         |=> system_data_lines_lo_oe_o && (system_data_lines_hi_oe_o == $past(master_wide_i)))
      else $error("master lanes wrong");
   hi_lane_a:
      assert property (system_data_lines_hi_oe_o
         |-> $past(bus_master_i && master_write_i && master_wide_i)) else $error("upper lanes driven");
   endian_hold_a:
      assert property (up_q == 2'h3 |-> $stable(big_endian_o)) else $error("byte order moved");
   irq_style_a:
      assert property (up_q == 2'h3 && ce_i |=> irq_pin_o == (big_endian_o ^ $past(irq_req_i)))
      else $error("irq polarity wrong");
   comp_hold_a:
      assert property ($past(packet_compress_out_oe_o) |-> packet_compress_out_oe_o)
      else $error("compress pin released");
   discard_one_a:
      assert property (packet_discard_o |=> !packet_discard_o) else $error("discard too long");
endmodule // pfpr_top_chk
bind pfpr_top pfpr_top_chk i_pfpr_top_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
   .bus_master_i(bus_master_i), .master_write_i(master_write_i), .master_wide_i(master_wide_i),
   .irq_req_i(irq_req_i), .irq_pin_o(irq_pin_o), .big_endian_o(big_endian_o),
   .loopback_indicator_oe_o(loopback_indicator_oe_o),
   .packet_compress_out_oe_o(packet_compress_out_oe_o),
   .system_data_lines_lo_oe_o(system_data_lines_lo_oe_o),
   .system_data_lines_hi_oe_o(system_data_lines_hi_oe_o), .packet_discard_o(packet_discard_o));
`default_nettype wire

// file: dv/pfpr_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfpr_rx_model (
   input  wire logic clk_i,
   output logic      rx_clk_o,
   output logic      crs_o,
   output logic      rej_n_o
);
   initial
   begin
      rx_clk_o = 1'b0;
      crs_o    = 1'b0;
      rej_n_o  = 1'b1;
   end
   // frame of len bits, reject low for cnt bits from bit at
   task automatic frame(input int len, input int at, input int cnt);
      for (int b = 0; b < len + 5; b++)
      begin
         @(posedge clk_i);
         crs_o    <= (b < len);
         rej_n_o  <= !(b >= at && b < at + cnt);
         rx_clk_o <= 1'b0;
         repeat (4) @(posedge clk_i);
         rx_clk_o <= 1'b1;
         repeat (3) @(posedge clk_i);
      end
      @(posedge clk_i);
      rx_clk_o <= 1'b0;
   endtask
endmodule // pfpr_rx_model
`default_nettype wire

// file: dv/pin_function_and_packet_reject_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pin_function_and_packet_reject_bench;
   import pfpr_pkg::*;
   logic        clk_i, sys_rst_i, ce_i, rd_i, wr_i, strap, rclk, crs, rej_n;
   logic [1:0]  adr;
   logic [3:0]  ben;
   logic [31:0] wdat, rdat, rd, mdat, dl;
   logic [15:0] sdat;
   logic        bm, mwr, mrd, mwide, srd, mval, mhit, irq;
   logic        wreq, lp, lp_oe, pc, pc_oe, mdir, irqp, lo_oe, hi_oe, lb_act, be_o, disc;
   int          num_errors, n_compared, n_disc;
   pfpr_top i_pfpr_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .avs_address_i(adr), .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdat),
      .avs_byteenable_i(ben), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .bus_style_select_i(strap), .receive_bit_clock_i(rclk), .carrier_sense_i(crs),
      .packet_reject_in_i(rej_n), .loopback_indicator_o(lp), .loopback_indicator_oe_o(lp_oe),
      .packet_compress_out_o(pc), .packet_compress_out_oe_o(pc_oe), .mem_dir_o(mdir),
      .irq_pin_o(irqp), .system_data_lines_o(dl), .system_data_lines_lo_oe_o(lo_oe),
      .system_data_lines_hi_oe_o(hi_oe), .bus_master_i(bm), .master_write_i(mwr),
      .master_read_i(mrd), .master_wide_i(mwide), .master_data_i(mdat), .slave_read_i(srd),
      .slave_data_i(sdat), .match_valid_i(mval), .match_hit_i(mhit), .irq_req_i(irq),
      .loopback_active_o(lb_act), .big_endian_o(be_o), .packet_discard_o(disc));
   pfpr_rx_model i_pfpr_rx_model (.clk_i(clk_i), .rx_clk_o(rclk), .crs_o(crs), .rej_n_o(rej_n));
   initial
   begin
      clk_i = 0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (disc === 1'b1) n_disc <= n_disc + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      @(posedge clk_i);
      adr <= a; wdat <= d; ben <= b; wr_i <= w; rd_i <= !w;
      do
      begin
         @(posedge clk_i);
      end while (wreq !== 1'b0);
      q = rdat;
      wr_i <= 1'b0;
      rd_i <= 1'b0;
   endtask
   task automatic do_reset(input logic s);
      @(posedge clk_i);
      strap <= s; sys_rst_i <= 1'b1; bm <= 1'b0; mwr <= 1'b0; mrd <= 1'b0; srd <= 1'b0;
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      settle();
      chk(lp_oe, 0);
      chk(pc_oe, 0);
      chk(be_o, s);
      bus(0, PFPR_ADDR_STATUS, 0, 4'hF, rd);
      chk(rd, {31'h0, s});
   endtask
   task automatic t_loop();
      bus(1, PFPR_ADDR_CFG, 32'h1, 4'h0, rd);
      settle();
      chk(lp_oe, 0);
      bus(1, PFPR_ADDR_CFG, 32'h1, 4'hF, rd);
      settle();
      chk({lp_oe, lp, lb_act}, 3'h7);
      bus(0, 2'h3, 0, 4'hF, rd);
      chk(rd, 0);
   endtask
   task automatic t_user();
      bus(1, PFPR_ADDR_CFG, 32'h3, 4'hF, rd);
      bus(1, PFPR_ADDR_CFG_TWO, 32'h0, 4'hF, rd);
      settle();
      chk(lp_oe, 0);
      chk(pc_oe, 1);
      @(posedge clk_i);
      bm <= 1'b1;
      settle();
      chk({lp_oe, lp}, 2'h2);
      bus(1, PFPR_ADDR_CFG_TWO, 32'h1, 4'hF, rd);
      settle();
      chk({lp_oe, lp}, 2'h3);
   endtask
   task automatic t_comp();
      for (int i = 0; i < 4; i++)
      begin
         bus(1, PFPR_ADDR_CFG_TWO, (i < 2) ? 32'h2 : 32'h6, 4'hF, rd);
         @(posedge clk_i);
         mval <= 1'b1; mhit <= i[0];
         @(posedge clk_i);
         mval <= 1'b0;
         settle();
         chk({pc_oe, pc}, {1'b1, i[0] ^ (i >= 2)});
      end
   endtask
   task automatic t_rej();
      i_pfpr_rx_model.frame(16, 5, 1);
      settle();
      chk(n_disc, 0);
      i_pfpr_rx_model.frame(16, 14, 2);
      settle();
      chk(n_disc, 1);
      bus(0, PFPR_ADDR_STATUS, 0, 4'hF, rd);
      chk(rd[3], 1);
      bus(1, PFPR_ADDR_STATUS, 32'h8, 4'hF, rd);
      bus(0, PFPR_ADDR_STATUS, 0, 4'hF, rd);
      chk(rd[3], 0);
   endtask
   task automatic t_pins(input logic s);
      @(posedge clk_i);
      bm <= 1'b1; mrd <= 1'b1; irq <= 1'b1; mwr <= 1'b0;
      settle();
      chk({mdir, irqp}, {s, !s});
      @(posedge clk_i);
      mrd <= 1'b0; mwr <= 1'b1; mwide <= 1'b1; mdat <= 32'h1122_3344;
      settle();
      chk(mdir, !s);
      chk(dl, s ? 32'h2211_4433 : 32'h1122_3344);
      chk({hi_oe, lo_oe}, 2'h3);
      @(posedge clk_i);
      mwide <= 1'b0;
      settle();
      chk({hi_oe, lo_oe}, 2'h1);
      chk(dl, s ? 32'h0000_4433 : 32'h0000_3344);
      @(posedge clk_i);
      bm <= 1'b0; mwr <= 1'b0; srd <= 1'b1; sdat <= 16'hA5C3;
      settle();
      chk({hi_oe, lo_oe}, 2'h1);
      chk(dl, 32'h0000_A5C3);
      // clock enable low freezes the lane drive
      @(posedge clk_i);
      ce_i <= 1'b0;
      srd <= 1'b0;
      settle();
      chk(lo_oe, 1);
      @(posedge clk_i);
      ce_i <= 1'b1;
      settle();
      chk(lo_oe, 0);
   endtask
   initial
   begin
      sys_rst_i = 1; ce_i = 1; rd_i = 0; wr_i = 0; strap = 0; adr = 0; ben = 4'hF; wdat = 0;
      bm = 0; mwr = 0; mrd = 0; mwide = 0; mdat = 0; srd = 0; sdat = 0; mval = 0; mhit = 0;
      irq = 0; num_errors = 0; n_compared = 0; n_disc = 0;
      do_reset(1'b0);
      t_loop();
      t_user();
      t_comp();
      t_rej();
      t_pins(1'b0);
      do_reset(1'b1);
      t_pins(1'b1);
      wrap_up();
   end
   initial
   begin
      #100000;
      num_errors++;
      wrap_up();
   end
endmodule // pin_function_and_packet_reject_bench
`default_nettype wire
